// ===== inc/dec_pkg.sv
package dec_pkg;

  // ---------------------------------------------------------------
  // register map on the device control bus
  // ---------------------------------------------------------------
  localparam int unsigned BUS_ADDR_W      = 10;
  localparam logic [9:0]  ADDR_COUNT_ZERO = 10'h200;
  localparam logic [9:0]  ADDR_COUNT_ONE  = 10'h201;
  localparam logic [9:0]  ADDR_CONTROL    = 10'h202;

  // ---------------------------------------------------------------
  // control register fields and widths
  // ---------------------------------------------------------------
  localparam int unsigned COUNT_W         = 32;
  localparam int unsigned NUM_COUNTERS    = 2;
  localparam int unsigned CTRL_ENABLE_LSB = 0;
  localparam int unsigned CTRL_EDGE_LSB   = 2;
  localparam int unsigned CTRL_USED_W     = 4;
  localparam logic [31:0] COUNT_RESET     = 32'h0000_0000;
  localparam logic [3:0]  CONTROL_RESET   = 4'h0;

  // edge select encoding: 0 falling, 1 rising
  localparam logic        EDGE_FALLING    = 1'b0;
  localparam logic        EDGE_RISING     = 1'b1;

endpackage

// ===== core/dec_edge_detect.sv
// two-stage latch then edge detect for one event input
module dec_edge_detect
  import dec_pkg::*;
(
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  input  wire logic i_event,
  input  wire logic i_rising,
  output logic      o_edge
);

  logic stage1_reg;
  logic stage2_reg;
  logic prev_reg;

  // ---------------------------------------------------------------
  // double latch, then one more stage for history
  // ---------------------------------------------------------------
  // stage1 feeds stage2 only; nothing else looks at it
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
      prev_reg   <= 1'b0;
    end
    else
    begin
      stage1_reg <= i_event;
      stage2_reg <= stage1_reg;
      prev_reg   <= stage2_reg;
    end
  end

  // edge of chosen polarity on the latched signal
  always_comb
  begin
    if (i_rising == EDGE_RISING)
      o_edge = stage2_reg & ~prev_reg;
    else
      o_edge = ~stage2_reg & prev_reg;
  end

  // a rising pin level shows as an edge on the second edge after it is sampled
  property p_latch_delay;
    @(posedge i_clock) disable iff (!i_rst_n)
      (i_rising && $rose(i_event)) ##1 (i_rising && i_event) ##1 i_rising |-> o_edge;
  endproperty
  a_latch_delay: assert property (p_latch_delay)
    else $error("rising edge not seen after two latch stages");

  property p_edge_polarity;
    @(posedge i_clock) disable iff (!i_rst_n)
      o_edge |-> (stage2_reg == i_rising) && (prev_reg != i_rising);
  endproperty
  a_edge_polarity: assert property (p_edge_polarity)
    else $error("edge pulse of wrong polarity");

endmodule

// ===== core/dec_event_counter.sv
module dec_event_counter
  import dec_pkg::*;
#(
  parameter int unsigned WIDTH = COUNT_W
)
(
  input  wire logic                  i_clock,
  input  wire logic                  i_rst_n,
  input  wire logic [1:0]            i_event_input_pins,
  input  wire logic                  i_bus_write,
  input  wire logic                  i_bus_read,
  input  wire logic [BUS_ADDR_W-1:0] i_bus_addr,
  input  wire logic [31:0]           i_bus_wdata,
  output logic      [31:0]           o_bus_rdata,
  output logic                       o_bus_ack,
  output logic      [1:0]            o_enable,
  output logic      [1:0]            o_edge_seen
);

  logic [WIDTH-1:0] count_reg [NUM_COUNTERS];
  logic [3:0]       control_reg;
  logic [3:0]       control_next;
  logic [1:0]       enable_rise;
  logic [1:0]       edge_pulse;
  logic             hit_zero;
  logic             hit_one;
  logic             hit_ctrl;
  logic             hit_any;
  logic [31:0]      rdata_next;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  assign hit_zero = (i_bus_addr == ADDR_COUNT_ZERO);
  assign hit_one  = (i_bus_addr == ADDR_COUNT_ONE);
  assign hit_ctrl = (i_bus_addr == ADDR_CONTROL);
  assign hit_any  = hit_zero | hit_one | hit_ctrl;

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  // reserved bits 4..31 are not stored and read as zero
  always_comb
  begin
    control_next = control_reg;
    if (i_bus_write && hit_ctrl)
      control_next = i_bus_wdata[CTRL_USED_W-1:0];
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      control_reg <= CONTROL_RESET;
    else
      control_reg <= control_next;
  end

  // enable bits in 0..1, edge bits in 2..3
  assign enable_rise = control_next[CTRL_ENABLE_LSB +: 2] & ~control_reg[CTRL_ENABLE_LSB +: 2];
  assign o_enable    = control_reg[CTRL_ENABLE_LSB +: 2];

  // ---------------------------------------------------------------
  // per-counter datapath
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_COUNTERS; g++)
    begin : g_counter
      logic wr_hit;

      assign wr_hit = i_bus_write && (g == 0 ? hit_zero : hit_one);

      dec_edge_detect u_edge (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_event (i_event_input_pins[g]),
        .i_rising(control_reg[CTRL_EDGE_LSB + g]),
        .o_edge  (edge_pulse[g])
      );

      // priority: enabling clear, then bus write, then edge count.
      // an edge in the cycle of the enabling write is dropped on purpose
      always_ff @(posedge i_clock or negedge i_rst_n)
      begin
        if (!i_rst_n)
          count_reg[g] <= WIDTH'(COUNT_RESET);
        else if (enable_rise[g])
          count_reg[g] <= WIDTH'(COUNT_RESET);
        else if (wr_hit)
          count_reg[g] <= i_bus_wdata[WIDTH-1:0];
        else if (control_reg[CTRL_ENABLE_LSB + g] && edge_pulse[g])
          count_reg[g] <= count_reg[g] + WIDTH'(1);
      end

      // disabled counter must not move unless written
      property p_hold_when_off;
        @(posedge i_clock) disable iff (!i_rst_n)
          (!control_reg[CTRL_ENABLE_LSB + g] && !enable_rise[g] && !wr_hit)
            |=> $stable(count_reg[g]);
      endproperty
      a_hold_when_off: assert property (p_hold_when_off)
        else $error("disabled counter changed");

      property p_count_step;
        @(posedge i_clock) disable iff (!i_rst_n)
          (control_reg[CTRL_ENABLE_LSB + g] && edge_pulse[g] && !wr_hit && !enable_rise[g])
            |=> count_reg[g] == $past(count_reg[g]) + WIDTH'(1);
      endproperty
      a_count_step: assert property (p_count_step)
        else $error("enabled counter missed an edge");

      property p_clear_on_enable;
        @(posedge i_clock) disable iff (!i_rst_n)
          enable_rise[g] |=> count_reg[g] == WIDTH'(COUNT_RESET);
      endproperty
      a_clear_on_enable: assert property (p_clear_on_enable)
        else $error("counter not cleared on enable");

      property p_write_lands;
        @(posedge i_clock) disable iff (!i_rst_n)
          (wr_hit && !enable_rise[g]) |=> count_reg[g] == $past(i_bus_wdata[WIDTH-1:0]);
      endproperty
      a_write_lands: assert property (p_write_lands)
        else $error("count write lost");

      property p_wrap;
        @(posedge i_clock) disable iff (!i_rst_n)
          (count_reg[g] == {WIDTH{1'b1}} && control_reg[CTRL_ENABLE_LSB + g]
            && edge_pulse[g] && !wr_hit && !enable_rise[g]) |=> count_reg[g] == '0;
      endproperty
      a_wrap: assert property (p_wrap)
        else $error("counter did not wrap to zero");
    end
  endgenerate

  // ---------------------------------------------------------------
  // read path and acknowledge
  // ---------------------------------------------------------------
  // unmapped reads return zero and are not acknowledged
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    if (hit_zero)
      rdata_next = 32'(count_reg[0]);
    else if (hit_one)
      rdata_next = 32'(count_reg[1]);
    else if (hit_ctrl)
      rdata_next = {28'h000_0000, control_reg};
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_bus_rdata <= 32'h0000_0000;
    else if (i_bus_read)
      o_bus_rdata <= rdata_next;
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_bus_ack <= 1'b0;
    else
      o_bus_ack <= (i_bus_read | i_bus_write) & hit_any;
  end

  // edge pulses of enabled counters held one cycle for observation
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_edge_seen <= 2'b00;
    else
      o_edge_seen <= edge_pulse & control_reg[CTRL_ENABLE_LSB +: 2];
  end

  property p_ack_follows;
    @(posedge i_clock) disable iff (!i_rst_n)
      (i_bus_read && hit_ctrl) |=> o_bus_ack && o_bus_rdata[31:4] == 28'h000_0000;
  endproperty
  a_ack_follows: assert property (p_ack_follows)
    else $error("control read not answered correctly");

  property p_ctrl_write;
    @(posedge i_clock) disable iff (!i_rst_n)
      (i_bus_write && hit_ctrl) |=> o_enable == $past(i_bus_wdata[1:0]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("enable bits not taken from write");

  // ---------------------------------------------------------------
  // bus answer checks
  // ---------------------------------------------------------------
  // idle cycles and unmapped places never answer
  property p_no_ack_unmapped;
    @(posedge i_clock) disable iff (!i_rst_n)
      !((i_bus_read || i_bus_write) && hit_any) |=> !o_bus_ack;
  endproperty
  a_no_ack_unmapped: assert property (p_no_ack_unmapped)
    else $error("answer without a mapped access");

  // count zero read returns the value held at the read edge
  property p_read_count;
    @(posedge i_clock) disable iff (!i_rst_n)
      (i_bus_read && hit_zero) |=> o_bus_ack && o_bus_rdata == $past(count_reg[0]);
  endproperty
  a_read_count: assert property (p_read_count)
    else $error("count read returned wrong value");

  // read data stays put until software reads again
  property p_rdata_holds;
    @(posedge i_clock) disable iff (!i_rst_n)
      !i_bus_read |=> $stable(o_bus_rdata);
  endproperty
  a_rdata_holds: assert property (p_rdata_holds)
    else $error("read data moved without a read");

endmodule

// ===== sim/dec_pin_model.sv
// ---------------------------------------------------------------
// external logic driving the two event pins
// ---------------------------------------------------------------
module dec_pin_model
(
  input  wire logic       i_clock,
  output logic      [1:0] o_pins
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] want = 2'h0;
  initial o_pins = 2'h0;
  // pins move on the falling edge, far from the sampling edge
  always @(negedge i_clock) o_pins <= want;
  // each level is held six cycles, longer than both latch stages
  task automatic set_pin(input int ch, input logic v);
    want[ch] = v;
    repeat (6) @(negedge i_clock);
  endtask
endmodule

// ===== sim/dec_event_counter_bench.sv
// ---------------------------------------------------------------
// self-checking bench for the event counter
// ---------------------------------------------------------------
module dec_event_counter_bench
  import dec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  i_clock = 1'b0;
  logic                  i_rst_n = 1'b0;
  logic [1:0]            pins;
  logic                  wr = 1'b0;
  logic                  rd = 1'b0;
  logic [BUS_ADDR_W-1:0] addr = '0;
  logic [31:0]           wdata = 32'h0;
  logic [31:0]           rdata;
  logic                  ack;
  logic [1:0]            en;
  logic [1:0]            seen;
  logic [31:0]           seen0 = 32'h0;
  logic [31:0]           seen1 = 32'h0;
  logic [32:0]           exp_q[$];
  logic [32:0]           note;
  logic [31:0]           v0, v1, n;
  int                    n_fail = 0;
  int                    n_tests = 0;
  int                    cycles = 0;
  always #50 i_clock = ~i_clock;
  dec_pin_model u_pin (.i_clock(i_clock), .o_pins(pins));
  dec_event_counter i_dut (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_event_input_pins(pins),
    .i_bus_write(wr), .i_bus_read(rd), .i_bus_addr(addr), .i_bus_wdata(wdata),
    .o_bus_rdata(rdata), .o_bus_ack(ack), .o_enable(en), .o_edge_seen(seen));
  task automatic bad(input string m);
    n_fail++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // one-cycle strobe; the note goes on the queue before the request
  task automatic wr_reg(input logic [9:0] a, input logic [31:0] d);
    @(negedge i_clock);
    exp_q.push_back({1'b0, 32'h0});
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge i_clock);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [9:0] a, input logic [31:0] e);
    @(negedge i_clock);
    exp_q.push_back({1'b1, e});
    rd = 1'b1;
    addr = a;
    @(negedge i_clock);
    rd = 1'b0;
  endtask
  task automatic pulse(input int ch);
    u_pin.set_pin(ch, 1'b1);
    u_pin.set_pin(ch, 1'b0);
  endtask
  // monitor: every ack retires the oldest note
  // counted-edge pulses are tallied here and judged at the end
  always @(negedge i_clock)
  begin
    if (seen[0] === 1'b1)
      seen0++;
    if (seen[1] === 1'b1)
      seen1++;
    if (ack === 1'b1)
    begin
      n_tests++;
      if (exp_q.size() == 0)
        bad("ack without request");
      else
      begin
        note = exp_q.pop_front();
        if (note[32] && rdata !== note[31:0])
          bad("read data mismatch");
      end
    end
  end
  // hang guard, far above the under two hundred cycles the run needs
  always @(posedge i_clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad("timeout");
      report_and_stop();
    end
  end
  initial
  begin
    void'($urandom(65));
    repeat (3) @(posedge i_clock);
    @(negedge i_clock) i_rst_n = 1'b1;
    rd_reg(ADDR_COUNT_ZERO, COUNT_RESET);
    rd_reg(ADDR_COUNT_ONE, COUNT_RESET);
    rd_reg(ADDR_CONTROL, 32'h0);
    v0 = $urandom;
    v1 = $urandom;
    wr_reg(ADDR_COUNT_ZERO, v0);
    wr_reg(ADDR_COUNT_ONE, v1);
    pulse(0);
    pulse(1);
    rd_reg(ADDR_COUNT_ZERO, v0);
    rd_reg(ADDR_COUNT_ONE, v1);
    wr_reg(ADDR_CONTROL, 32'h5);
    n_tests++;
    if (en !== 2'h1) bad("enable bits");
    rd_reg(ADDR_COUNT_ZERO, 32'h0);
    n = 32'h1 + ($urandom % 5);
    repeat (n) pulse(0);
    pulse(1);
    rd_reg(ADDR_COUNT_ZERO, n);
    rd_reg(ADDR_COUNT_ONE, v1);
    wr_reg(ADDR_CONTROL, 32'h0);
    // both on, falling edges, reserved bits set and dropped
    wr_reg(ADDR_CONTROL, 32'hFFFF_FFF3);
    rd_reg(ADDR_CONTROL, 32'h3);
    u_pin.set_pin(0, 1'b1);
    rd_reg(ADDR_COUNT_ZERO, 32'h0);
    u_pin.set_pin(0, 1'b0);
    rd_reg(ADDR_COUNT_ZERO, 32'h1);
    rd_reg(ADDR_COUNT_ONE, 32'h0);
    wr_reg(ADDR_COUNT_ONE, 32'hFFFF_FFFF);
    pulse(1);
    rd_reg(ADDR_COUNT_ONE, 32'h0);
    // counter one stays on and turns rising, counter zero off and holds
    wr_reg(ADDR_CONTROL, 32'hA);
    pulse(1);
    rd_reg(ADDR_COUNT_ONE, 32'h1);
    rd_reg(ADDR_COUNT_ZERO, 32'h1);
    // unmapped place: no ack, zero data over the last nonzero read
    @(negedge i_clock);
    rd = 1'b1;
    addr = 10'h203;
    @(negedge i_clock);
    rd = 1'b0;
    repeat (2) @(negedge i_clock);
    n_tests++;
    if (rdata !== 32'h0) bad("unmapped read data");
    n_tests++;
    if (exp_q.size() != 0) bad("request never answered");
    // zero: n rising plus one falling; one: one falling plus one rising
    n_tests++;
    if (seen0 !== n + 32'h1 || seen1 !== 32'h2) bad("edge pulse count");
    report_and_stop();
  end
endmodule
